// ---- trs_user.sv ----
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "trs_regs.svh"
// Overview of operation
// - Hold all three resets before PLL reconfig
// - Strobe config update after last scan bit
// - Transceiver flags PLL reconfiguration done
// - Pulse PLL reset after reconfiguration done
// - Transceiver raises lock after PLL locks
// - Release transmit reset after PLL lock
// - Wait five cycles after lock, release analog
// - After freq lock, wait LTD, release digital
// - Write mode, pulse write-all, assert resets
// - Write-all starts controller, busy shows it
// - Controller flags channel reconfiguration done
// - Transmit release between done and analog release
// - Five cycles after done before analog release
// - Freq lock, then LTD, then digital release
// - Power-down stops every channel and block
// - Power-down pulse lasts at least 1 us
// - No power-down during offset cancellation
// - Busy falling marks offset cancellation done
// - Busy pulses at power-up, then on access
// - Simulation busy lasts about 20 cycles
// - Power-down-only simulation holds it 1 us
// - PCIe simulation forces idle during sequence and power-down
module trs_user #(
   parameter int LTD_CYC = `TRS_LTD_CYC,
   parameter int PAR_CYC = `TRS_PAR_CYC,
   parameter int PD_CYC = `TRS_PD_MIN_CYC,
   parameter int SCAN_BITS = `TRS_SCAN_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   trs_if.user lnk,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   import trs_pkg::*;
   localparam int W = `TRS_CNT_W;
   typedef enum logic [3:0] {
      S_IDLE, S_SCAN, S_WDONE, S_ARST, S_WLOCK, S_WAIT5, S_WFREQ, S_WLTD, S_WA, S_WCDONE, S_PD
   } trs_st_type;
   trs_st_type st_r, st_nxt;
   trs_op_type op_r;
   logic [W-1:0] cnt_r;
   logic [3:0] ctrl_r;
   trs_mode_type mode_r;
   logic wr_ph_r;
   logic [31:0] addr_r;
   logic txr_r, rxa_r, rxd_r, area_r, upd_r, wa_r, pd_r, idle_r;
   logic seen_busy_r;
   // ==========================================
   // AHB-Lite slave: zero wait states, always OKAY
   wire take = hsel && hready && htrans[1];
   wire wr_ctrl = wr_ph_r && addr_r == `TRS_OFF_CTRL;
   wire wr_mode = wr_ph_r && addr_r == `TRS_OFF_MODE;
   wire busy_seq = st_r != S_IDLE;
   wire [31:0] stat_w = {24'h0, 1'b0, lnk.busy, lnk.rx_freq_locked, lnk.pll_locked,
      lnk.chan_reconfig_done, lnk.pll_reconfig_done, seen_busy_r, busy_seq};
   wire [31:0] rd_w = (haddr == `TRS_OFF_CTRL) ? {28'h0, ctrl_r} :
      (haddr == `TRS_OFF_MODE) ? {29'h0, mode_r} :
      (haddr == `TRS_OFF_STAT) ? stat_w : 32'h0;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_ph_r <= 1'b0;
         addr_r <= 32'h0;
         hrdata <= 32'h0;
      end else begin
         wr_ph_r <= take && hwrite;
         addr_r <= haddr;
         if (take && !hwrite) hrdata <= rd_w;
      end
   end
   // ==========================================
   // Sequencer
   wire cnt_hit = cnt_r == W'(0);
   wire go_pll = wr_ctrl && hwdata[`TRS_CTRL_PLLRC] && st_r == S_IDLE && seen_busy_r;
   wire go_chan = wr_ctrl && hwdata[`TRS_CTRL_CHRC] && st_r == S_IDLE && seen_busy_r;
   // Power-down is taken only once offset cancellation has ended
   wire go_pd = wr_ctrl && hwdata[`TRS_CTRL_PD] && st_r == S_IDLE && seen_busy_r && !lnk.busy;
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         S_IDLE: begin
            // After offset cancel the receiver still waits for lock and lock-to-data
            if (!seen_busy_r && !lnk.busy) st_nxt = S_WLOCK;
            else if (go_pd) st_nxt = S_PD;
            else if (go_pll) st_nxt = S_SCAN;
            else if (go_chan) st_nxt = S_WA;
         end
         S_SCAN: if (cnt_hit) st_nxt = S_WDONE;
         S_WDONE: if (lnk.pll_reconfig_done) st_nxt = S_ARST;
         S_ARST: if (cnt_hit) st_nxt = S_WLOCK;
         S_WLOCK: if (lnk.pll_locked) st_nxt = S_WAIT5;
         S_WA: st_nxt = S_WCDONE;
         S_WCDONE: if (lnk.chan_reconfig_done && !lnk.busy) st_nxt = S_WAIT5;
         S_WAIT5: if (cnt_hit) st_nxt = S_WFREQ;
         S_WFREQ: if (lnk.rx_freq_locked) st_nxt = S_WLTD;
         S_WLTD: if (cnt_hit) st_nxt = S_IDLE;
         S_PD: if (cnt_hit) st_nxt = S_IDLE;
         default: st_nxt = S_IDLE;
      endcase
   end
   // Count loaded on each state entry, counts down to zero
   wire entering = st_nxt != st_r;
   wire [W-1:0] load_w = (st_nxt == S_SCAN) ? W'(SCAN_BITS - 1) :
      (st_nxt == S_ARST) ? W'(PD_CYC - 1) :
      (st_nxt == S_WAIT5) ? W'(PAR_CYC - 1) :
      (st_nxt == S_WLTD) ? W'(LTD_CYC - 1) :
      (st_nxt == S_PD) ? W'(PD_CYC - 1) : W'(0);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r <= S_IDLE;
         cnt_r <= '0;
         op_r <= TRS_OP_IDLE;
         ctrl_r <= 4'h0;
         mode_r <= 3'h0;
         seen_busy_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= entering ? load_w : (cnt_hit ? cnt_r : cnt_r - W'(1));
         if (go_pll && !go_pd) op_r <= TRS_OP_PLL;
         else if (go_chan && !go_pd) op_r <= TRS_OP_CHAN;
         if (wr_ctrl) ctrl_r <= hwdata[3:0];
         if (wr_mode) mode_r <= hwdata[2:0];
         // Offset cancellation ends on the first busy fall
         if (!lnk.busy) seen_busy_r <= 1'b1;
      end
   end
   // ==========================================
   // Reset and strobe outputs, registered
   wire in_seq = st_r != S_IDLE && st_r != S_PD;
   wire txr_nxt = !seen_busy_r || (st_nxt inside {S_SCAN, S_WDONE, S_ARST, S_WLOCK, S_WA, S_WCDONE});
   wire rxa_nxt = !seen_busy_r || (st_nxt != S_IDLE && st_nxt != S_WFREQ && st_nxt != S_WLTD
      && st_nxt != S_PD);
   wire rxd_nxt = !seen_busy_r || (st_nxt != S_IDLE && st_nxt != S_PD);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         txr_r <= 1'b1;
         rxa_r <= 1'b1;
         rxd_r <= 1'b1;
         area_r <= 1'b0;
         upd_r <= 1'b0;
         wa_r <= 1'b0;
         pd_r <= 1'b0;
         idle_r <= 1'b0;
      end else begin
         txr_r <= txr_nxt;
         rxa_r <= rxa_nxt;
         rxd_r <= rxd_nxt;
         upd_r <= st_r == S_SCAN && cnt_hit;
         area_r <= st_nxt == S_ARST;
         wa_r <= st_nxt == S_WA;
         pd_r <= st_nxt == S_PD;
         // PCIe: force idle while a sequence or power-down runs
         idle_r <= ctrl_r[`TRS_CTRL_PCIE] && (in_seq || st_r == S_PD);
      end
   end
   assign lnk.tx_digital_reset = txr_r;
   assign lnk.rx_analog_reset = rxa_r;
   assign lnk.rx_digital_reset = rxd_r;
   assign lnk.pll_areset = area_r;
   assign lnk.pll_cfg_update = upd_r;
   assign lnk.write_all = wa_r;
   assign lnk.block_powerdown = pd_r;
   assign lnk.reconfig_mode_sel = mode_r;
   assign lnk.tx_force_idle = idle_r;
endmodule : trs_user

// ---- trs_regs.svh ----
`ifndef TRS_REGS_SVH
`define TRS_REGS_SVH
// Timing in ns, derived cycle counts at 10 ns per clock
`define TRS_CLK_NS 10
`define TRS_PD_MIN_NS 1000
`define TRS_PD_MIN_CYC ((`TRS_PD_MIN_NS + `TRS_CLK_NS - 1) / `TRS_CLK_NS)
`define TRS_PAR_CYC 5
`define TRS_BUSY_CYC 20
`define TRS_LTD_NS 4000
`define TRS_LTD_CYC (`TRS_LTD_NS / `TRS_CLK_NS)
`define TRS_SCAN_CYC 16
`define TRS_LOCK_CYC 32
`define TRS_FREQ_CYC 16
`define TRS_CNT_W 16
// Register offsets of the user controller
`define TRS_OFF_CTRL 32'h0000_0000
`define TRS_OFF_MODE 32'h0000_0004
`define TRS_OFF_STAT 32'h0000_0008
// Control bit positions
`define TRS_CTRL_PLLRC 0
`define TRS_CTRL_CHRC 1
`define TRS_CTRL_PD 2
`define TRS_CTRL_PCIE 3
`endif

// ---- trs_pkg.sv ----
package trs_pkg;
   typedef enum logic [1:0] {
      TRS_OP_IDLE,
      TRS_OP_PLL,
      TRS_OP_CHAN
   } trs_op_type;
   typedef logic [2:0] trs_mode_type;
endpackage : trs_pkg

// ---- trs_if.sv ----
`timescale 1ns/1ps
interface trs_if;
   logic tx_digital_reset;
   logic rx_analog_reset;
   logic rx_digital_reset;
   logic pll_areset;
   logic pll_cfg_update;
   logic block_powerdown;
   logic write_all;
   logic [2:0] reconfig_mode_sel;
   logic tx_force_idle;
   logic pll_reconfig_done;
   logic pll_locked;
   logic chan_reconfig_done;
   logic busy;
   logic rx_freq_locked;
   modport dev (
      input tx_digital_reset, rx_analog_reset, rx_digital_reset, pll_areset, pll_cfg_update,
      input block_powerdown, write_all, reconfig_mode_sel, tx_force_idle,
      output pll_reconfig_done, pll_locked, chan_reconfig_done, busy, rx_freq_locked
   );
   modport user (
      output tx_digital_reset, rx_analog_reset, rx_digital_reset, pll_areset, pll_cfg_update,
      output block_powerdown, write_all, reconfig_mode_sel, tx_force_idle,
      input pll_reconfig_done, pll_locked, chan_reconfig_done, busy, rx_freq_locked
   );
endinterface : trs_if

// ---- trs_xcvr.sv ----
`timescale 1ns/1ps
`include "trs_regs.svh"
module trs_xcvr #(
   parameter int BUSY_CYC = `TRS_BUSY_CYC,
   parameter int SCAN_CYC = `TRS_SCAN_CYC,
   parameter int LOCK_CYC = `TRS_LOCK_CYC,
   parameter int FREQ_CYC = `TRS_FREQ_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   trs_if.dev lnk,
   output logic powered_down,
   output logic [2:0] active_mode
);
   import trs_pkg::*;
   localparam int W = `TRS_CNT_W;
   logic [W-1:0] busy_cnt_r;
   logic [W-1:0] scan_cnt_r;
   logic [W-1:0] lock_cnt_r;
   logic [W-1:0] freq_cnt_r;
   logic busy_r;
   logic offset_done_r;
   logic scan_act_r;
   logic pll_done_r;
   logic chan_done_r;
   logic locked_r;
   logic freq_r;
   logic wa_d_r;
   logic [2:0] mode_r;
   wire pd = lnk.block_powerdown;
   wire wa_rise = lnk.write_all & ~wa_d_r;
   wire busy_end = busy_r && busy_cnt_r == W'(BUSY_CYC - 1);
   assign lnk.busy = busy_r;
   assign lnk.pll_reconfig_done = pll_done_r;
   assign lnk.chan_reconfig_done = chan_done_r;
   assign lnk.pll_locked = locked_r;
   assign lnk.rx_freq_locked = freq_r;
   assign powered_down = pd;
   assign active_mode = mode_r;
   // ==========================================
   // Busy: offset cancel at power-up, then reconfiguration
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busy_r <= 1'b1;
         busy_cnt_r <= '0;
         offset_done_r <= 1'b0;
         wa_d_r <= 1'b0;
         chan_done_r <= 1'b0;
         mode_r <= 3'h0;
      end else begin
         wa_d_r <= lnk.write_all;
         if (pd && offset_done_r) begin
            busy_r <= 1'b0;
            chan_done_r <= 1'b0;
         end else if (busy_end) begin
            busy_r <= 1'b0;
            busy_cnt_r <= '0;
            if (offset_done_r) begin
               chan_done_r <= 1'b1;
               mode_r <= lnk.reconfig_mode_sel;
            end
            offset_done_r <= 1'b1;
         end else if (busy_r) begin
            busy_cnt_r <= busy_cnt_r + W'(1);
         end else if (wa_rise) begin
            busy_r <= 1'b1;
            chan_done_r <= 1'b0;
         end
      end
   end
   // ==========================================
   // PLL scan chain, lock and receiver frequency lock
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         scan_act_r <= 1'b0;
         scan_cnt_r <= '0;
         pll_done_r <= 1'b0;
         lock_cnt_r <= '0;
         locked_r <= 1'b0;
         freq_cnt_r <= '0;
         freq_r <= 1'b0;
      end else begin
         if (lnk.pll_cfg_update && !scan_act_r) begin
            scan_act_r <= 1'b1;
            scan_cnt_r <= '0;
            pll_done_r <= 1'b0;
         end else if (scan_act_r) begin
            scan_cnt_r <= scan_cnt_r + W'(1);
            if (scan_cnt_r == W'(SCAN_CYC - 1)) begin
               scan_act_r <= 1'b0;
               pll_done_r <= 1'b1;
            end
         end else if (lnk.pll_areset) begin
            pll_done_r <= 1'b0;
         end
         // Lock only counts while out of reset and powered
         if (lnk.pll_areset || pd) begin
            lock_cnt_r <= '0;
            locked_r <= 1'b0;
         end else if (!locked_r) begin
            lock_cnt_r <= lock_cnt_r + W'(1);
            locked_r <= lock_cnt_r == W'(LOCK_CYC - 1);
         end
         if (lnk.rx_analog_reset || !locked_r || pd) begin
            freq_cnt_r <= '0;
            freq_r <= 1'b0;
         end else if (!freq_r) begin
            freq_cnt_r <= freq_cnt_r + W'(1);
            freq_r <= freq_cnt_r == W'(FREQ_CYC - 1);
         end
      end
   end
endmodule : trs_xcvr

// ---- trs_props.sv ----
`timescale 1ns/1ps
`include "trs_regs.svh"
// ==========================================
// Link checker, sits beside the interface
module trs_props #(
   parameter int LTD_CYC = 20,
   parameter int PD_CYC = `TRS_PD_MIN_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic tx_digital_reset,
   input wire logic rx_analog_reset,
   input wire logic rx_digital_reset,
   input wire logic pll_areset,
   input wire logic pll_cfg_update,
   input wire logic block_powerdown,
   input wire logic write_all,
   input wire logic pll_reconfig_done,
   input wire logic pll_locked,
   input wire logic chan_reconfig_done,
   input wire logic busy,
   input wire logic rx_freq_locked
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // Power-down pulse is far longer than a repetition may count
   logic [15:0] pd_len_r;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) pd_len_r <= 16'h0;
      else pd_len_r <= block_powerdown ? pd_len_r + 16'h1 : 16'h0;
   end
   a_update_resets_held: assert property ($rose(pll_cfg_update) |-> tx_digital_reset && rx_analog_reset && rx_digital_reset)
      else $error("update strobe while a channel reset is low");
   a_done_after_update: assert property ($rose(pll_cfg_update) |-> ##[1:24] pll_reconfig_done)
      else $error("no reconfiguration done after update");
   a_areset_after_done: assert property ($rose(pll_areset) |-> pll_reconfig_done)
      else $error("pll reset before reconfiguration done");
   a_tx_release_lock: assert property ($fell(tx_digital_reset) |-> pll_locked || chan_reconfig_done)
      else $error("transmit reset released without lock or done");
   // Five cycles back, the lock or the done flag must already stand
   a_analog_wait_five: assert property ($fell(rx_analog_reset) |->
      !tx_digital_reset && ($past(pll_locked, 5) || $past(chan_reconfig_done, 5)))
      else $error("analog reset released too early");
   a_digital_wait_ltd: assert property ($fell(rx_digital_reset) |-> $past(rx_freq_locked, LTD_CYC))
      else $error("digital reset released before lock-to-data time");
   a_busy_on_write: assert property ($rose(write_all) && !busy |=> busy)
      else $error("busy did not follow write-all");
   a_busy_length: assert property ($rose(busy) |-> busy[*8] ##[10:14] $fell(busy))
      else $error("busy pulse length out of range");
   a_done_after_busy: assert property ($rose(chan_reconfig_done) |-> $past(busy))
      else $error("channel done without busy");
   a_pd_width_exact: assert property ($fell(block_powerdown) |-> pd_len_r == 16'(PD_CYC))
      else $error("power-down pulse width wrong");
   a_pd_kills_lock: assert property (block_powerdown |=> !pll_locked && !rx_freq_locked)
      else $error("lock survives power-down");
   a_pd_not_in_cancel: assert property ($rose(block_powerdown) |-> !busy)
      else $error("power-down during offset cancellation");
   c_pll_flow: cover property ($rose(pll_areset));
   c_chan_flow: cover property ($rose(chan_reconfig_done));
   c_pd_pulse: cover property ($rose(block_powerdown));
endmodule : trs_props

// ---- trs_test.sv ----
`timescale 1ns/1ps
module trs_test;
   import trs_pkg::*;
   logic mclk, rstn, hsel, hwrite, hready, hreadyout, hresp, powered_down;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, active_mode;
   int n_fail, checks_done, pd_n;
   trs_if lnk ();
   // Short counts keep the run small; expectations follow these values
   trs_xcvr #(.LOCK_CYC(8)) trs_xcvr_i (.mclk(mclk), .rstn(rstn), .lnk(lnk), .powered_down(powered_down),
      .active_mode(active_mode));
   trs_user #(.LTD_CYC(20)) trs_user_i (.mclk(mclk), .rstn(rstn), .lnk(lnk), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));
   trs_props #(.LTD_CYC(20)) trs_props_i (.mclk(mclk), .rstn(rstn), .tx_digital_reset(lnk.tx_digital_reset),
      .rx_analog_reset(lnk.rx_analog_reset), .rx_digital_reset(lnk.rx_digital_reset), .pll_areset(lnk.pll_areset),
      .pll_cfg_update(lnk.pll_cfg_update), .block_powerdown(lnk.block_powerdown), .write_all(lnk.write_all),
      .pll_reconfig_done(lnk.pll_reconfig_done), .pll_locked(lnk.pll_locked), .busy(lnk.busy),
      .chan_reconfig_done(lnk.chan_reconfig_done), .rx_freq_locked(lnk.rx_freq_locked));
   assign hready = hreadyout;
   // ==========================================
   // Checks and bus access
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask : xfer
   // Polls status until the sequencer is idle and offset cancel is over
   task automatic wait_idle;
      for (int i = 0; i < 300; i++) begin
         xfer(1'b0, 32'h8, 32'h0);
         if (rd[1:0] === 2'b10) break;
      end
   endtask : wait_idle
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // ==========================================
   // Clock, watchdog and scenarios
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (powered_down === 1'b1) pd_n <= pd_n + 1;
   initial begin
      #200000;
      n_fail++;
      print_verdict;
   end
   initial begin
      {rstn, hsel, hwrite, htrans, haddr, hwdata, pd_n, n_fail, checks_done} = '0;
      hsize = 3'h2;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      xfer(1'b0, 32'h8, 32'h0);
      chk(rd & 32'h42, 32'h40);
      chk({29'h0, lnk.tx_digital_reset, lnk.rx_analog_reset, lnk.rx_digital_reset}, 32'h7);
      wait_idle;
      chk(rd & 32'h41, 32'h0);
      xfer(1'b1, 32'h0, 32'h1);
      wait_idle;
      chk(rd & 32'h37, 32'h32);
      chk({29'h0, lnk.tx_digital_reset, lnk.rx_analog_reset, lnk.rx_digital_reset}, 32'h0);
      for (int m = 0; m < 8; m++) begin
         xfer(1'b1, 32'h4, 32'(m));
         xfer(1'b1, 32'h0, 32'h2);
         wait_idle;
         chk(rd & 32'h3B, 32'h3A);
         chk({29'h0, active_mode}, 32'(m));
         chk({29'h0, lnk.reconfig_mode_sel}, 32'(m));
      end
      xfer(1'b0, 32'h4, 32'h0);
      chk(rd & 32'h7, 32'h7);
      // Unmapped place: writes vanish, reads give zero
      xfer(1'b1, 32'hC, 32'hFFFF_FFFF);
      xfer(1'b0, 32'hC, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, 32'h0, 32'hA);
      repeat (2) @(posedge mclk);
      chk({31'h0, lnk.tx_force_idle}, 32'h1);
      wait_idle;
      chk({31'h0, lnk.tx_force_idle}, 32'h0);
      xfer(1'b1, 32'h0, 32'h4);
      repeat (20) @(posedge mclk);
      xfer(1'b0, 32'h8, 32'h0);
      chk(rd & 32'h30, 32'h0);
      repeat (100) @(posedge mclk);
      chk(32'(pd_n), 32'h64);
      print_verdict;
   end
endmodule : trs_test
